// *** core/drs_supervisor.sv ***
// Behaviour
// - secondary reset low on supply fault or manual
// - secondary reset stretched one timeout after recovery
// - low manual reset input asserts reset
// - reset held while manual low, then timeout
// - unconnected manual reset input reads inactive
// - steady watchdog input beyond timeout forces reset
// - watchdog counter clears on reset or edge
// - long initial watchdog timeout after every reset
// - first kick edge selects short normal timeout
// - floating watchdog input disables the watchdog
// - auxiliary undervoltage asserts reset
// - primary reset stretched after every cause clears
// - renewed fault restarts the timeout from zero
// - power-fail output follows sense, no stretch
// - active-high reset is exact complement of primary
`timescale 1ns/10ps
`default_nettype none
module drs_supervisor #(
  parameter int unsigned RESET_TIMEOUT_CYCLES = 32'(drs_pkg::RESET_TIMEOUT_CYC),
  parameter int unsigned WD_LONG_CYCLES = 32'(drs_pkg::WD_LONG_CYC),
  parameter int unsigned WD_NORMAL_CYCLES = 32'(drs_pkg::WD_NORMAL_CYC)
) (
  input wire logic clk, // 50 MHz time base
  input wire logic rst, // synchronous, active high
  input wire logic primaryUndervolt, // primary supply below threshold
  input wire logic secondaryUndervolt, // secondary supply below threshold
  input wire logic aux_undervoltage_in, // auxiliary monitor below reference
  input wire logic manual_reset_n, // manual reset, active low
  input wire logic manualResetFloat, // manual reset pin left open
  input wire logic watchdog_kick, // watchdog input level
  input wire logic watchdogFloat, // watchdog pin left floating
  input wire logic powerfail_sense_in, // power-fail sense below reference
  output logic primary_reset_n, // primary reset, active low
  output logic secondary_reset_n, // secondary reset, active low
  output logic primaryReset, // primary reset, active high
  output logic powerfail_out_n // power-fail flag, active low
);

  // counts the logic cannot serve are refused at elaboration
  if (RESET_TIMEOUT_CYCLES < 1 || WD_NORMAL_CYCLES < 1 || WD_LONG_CYCLES < WD_NORMAL_CYCLES) begin
    $error("drs_supervisor: timeout counts out of range");
  end

  localparam logic [drs_pkg::CNT_W-1:0] RST_LAST = drs_pkg::CNT_W'(RESET_TIMEOUT_CYCLES - 1);
  localparam logic [drs_pkg::CNT_W-1:0] WD_LONG_LAST = drs_pkg::CNT_W'(WD_LONG_CYCLES - 1);
  localparam logic [drs_pkg::CNT_W-1:0] WD_NORM_LAST = drs_pkg::CNT_W'(WD_NORMAL_CYCLES - 1);
  localparam logic [drs_pkg::CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [drs_pkg::CNT_W-1:0] CNT_ONE = drs_pkg::CNT_W'(1);

  logic [drs_pkg::NUM_SYNC-1:0] rawIn;
  logic [drs_pkg::NUM_SYNC-1:0] syncFirst;
  logic [drs_pkg::NUM_SYNC-1:0] syncIn;
  logic kickPrev;
  logic kickEdge;
  logic priUv;
  logic secUv;
  logic auxUv;
  logic mrLow;
  logic wdOff;
  logic wdFault;
  drs_pkg::drs_wd_mode_e wdMode;
  logic [drs_pkg::CNT_W-1:0] wdCnt;
  logic [drs_pkg::CNT_W-1:0] wdLast;
  logic [drs_pkg::NUM_CH-1:0] chCause;
  logic [drs_pkg::NUM_CH-1:0] chResetN;
  logic [drs_pkg::NUM_CH-1:0] next_chResetN;
  logic [drs_pkg::CNT_W-1:0] chCnt [drs_pkg::NUM_CH];

  // an open manual reset pin reads as released, like a pull-up
  always_comb begin
    rawIn = '0;
    rawIn[drs_pkg::S_PRI_UV] = primaryUndervolt;
    rawIn[drs_pkg::S_SEC_UV] = secondaryUndervolt;
    rawIn[drs_pkg::S_AUX_UV] = aux_undervoltage_in;
    rawIn[drs_pkg::S_MR_N] = manualResetFloat | manual_reset_n;
    rawIn[drs_pkg::S_KICK] = watchdog_kick;
    rawIn[drs_pkg::S_WD_FLOAT] = watchdogFloat;
    rawIn[drs_pkg::S_PF_LOW] = powerfail_sense_in;
  end

  // two-stage synchronisers; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      syncFirst <= '0;
      syncIn <= '0;
    end else begin
      syncFirst <= rawIn;
      syncIn <= syncFirst;
    end
  end

  assign priUv = syncIn[drs_pkg::S_PRI_UV];
  assign secUv = syncIn[drs_pkg::S_SEC_UV];
  assign auxUv = syncIn[drs_pkg::S_AUX_UV];
  assign mrLow = ~syncIn[drs_pkg::S_MR_N];
  assign wdOff = syncIn[drs_pkg::S_WD_FLOAT];

  // previous kick level for edge detection on the synchronised copy
  always_ff @(posedge clk) begin
    if (rst) begin
      kickPrev <= 1'b0;
    end else begin
      kickPrev <= syncIn[drs_pkg::S_KICK];
    end
  end

  // a floating pin has no meaningful level, so its edges are not kicks
  assign kickEdge = (syncIn[drs_pkg::S_KICK] ^ kickPrev) & ~wdOff;

  // causes per channel; the secondary channel sees supplies and manual only
  assign chCause[drs_pkg::CH_PRI] = priUv | secUv | auxUv | mrLow | wdFault;
  assign chCause[drs_pkg::CH_SEC] = priUv | secUv | mrLow;

  // one stretch timer per reset channel
  for (genvar ch = 0; ch < drs_pkg::NUM_CH; ch++) begin : g_ch
    always_comb begin
      if (chCause[ch]) begin
        next_chResetN[ch] = 1'b0;
      end else if (!chResetN[ch] && chCnt[ch] == RST_LAST) begin
        next_chResetN[ch] = 1'b1;
      end else begin
        next_chResetN[ch] = chResetN[ch];
      end
    end

    // a cause during the stretch restarts it from zero
    always_ff @(posedge clk) begin
      if (rst) begin
        chResetN[ch] <= 1'b0;
        chCnt[ch] <= CNT_ZERO;
      end else begin
        chResetN[ch] <= next_chResetN[ch];
        if (chCause[ch] || chResetN[ch]) begin
          chCnt[ch] <= CNT_ZERO;
        end else begin
          chCnt[ch] <= chCnt[ch] + CNT_ONE;
        end
      end
    end
  end

  // both primary outputs registered from the same next value, so they never disagree
  always_ff @(posedge clk) begin
    if (rst) begin
      primary_reset_n <= 1'b0;
      primaryReset <= 1'b1;
      secondary_reset_n <= 1'b0;
    end else begin
      primary_reset_n <= next_chResetN[drs_pkg::CH_PRI];
      primaryReset <= ~next_chResetN[drs_pkg::CH_PRI];
      secondary_reset_n <= next_chResetN[drs_pkg::CH_SEC];
    end
  end

  // power-fail flag follows the sense input with no stretch
  always_ff @(posedge clk) begin
    if (rst) begin
      powerfail_out_n <= 1'b1;
    end else begin
      powerfail_out_n <= ~syncIn[drs_pkg::S_PF_LOW];
    end
  end

  assign wdLast = (wdMode == drs_pkg::WD_LONG) ? WD_LONG_LAST : WD_NORM_LAST;

  // watchdog mode: long after any reset, normal after the first kick
  always_ff @(posedge clk) begin
    if (rst) begin
      wdMode <= drs_pkg::WD_LONG;
    end else begin
      unique case (wdMode)
        drs_pkg::WD_LONG: begin
          if (chResetN[drs_pkg::CH_PRI] && kickEdge) begin
            wdMode <= drs_pkg::WD_NORMAL;
          end
        end
        drs_pkg::WD_NORMAL: begin
          if (!chResetN[drs_pkg::CH_PRI]) begin
            wdMode <= drs_pkg::WD_LONG;
          end
        end
      endcase
    end
  end

  // watchdog counter; the fault is a one-cycle pulse into the primary channel
  always_ff @(posedge clk) begin
    if (rst) begin
      wdCnt <= CNT_ZERO;
      wdFault <= 1'b0;
    end else if (!chResetN[drs_pkg::CH_PRI] || kickEdge || wdOff) begin
      wdCnt <= CNT_ZERO;
      wdFault <= 1'b0;
    end else if (wdCnt == wdLast) begin
      wdCnt <= CNT_ZERO;
      wdFault <= 1'b1;
    end else begin
      wdCnt <= wdCnt + CNT_ONE;
      wdFault <= 1'b0;
    end
  end

  // helper for checks: cycles since each channel's cause last stood
  logic [drs_pkg::CNT_W-1:0] quietCnt [drs_pkg::NUM_CH];
  for (genvar ch = 0; ch < drs_pkg::NUM_CH; ch++) begin : g_quiet
    always_ff @(posedge clk) begin
      if (rst || chCause[ch]) begin
        quietCnt[ch] <= CNT_ZERO;
      end else if (quietCnt[ch] != '1) begin
        quietCnt[ch] <= quietCnt[ch] + CNT_ONE;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sec_assert;
    (priUv || secUv || mrLow) |=> !secondary_reset_n;
  endproperty
  a_sec_assert: assert property (p_sec_assert) else $error("secondary reset not asserted");

  property p_sec_release;
    $rose(secondary_reset_n) |-> quietCnt[drs_pkg::CH_SEC] == RESET_TIMEOUT_CYCLES;
  endproperty
  a_sec_release: assert property (p_sec_release) else $error("secondary stretch wrong");

  property p_mr_assert;
    mrLow |=> (!primary_reset_n && !secondary_reset_n);
  endproperty
  a_mr_assert: assert property (p_mr_assert) else $error("manual reset ignored");

  property p_mr_hold;
    (mrLow ##1 !mrLow) |=> !primary_reset_n [*1] ##0 quietCnt[drs_pkg::CH_PRI] <= CNT_ONE;
  endproperty
  a_mr_hold: assert property (p_mr_hold) else $error("reset dropped at manual release");

  property p_mr_float;
    (manualResetFloat ##2 !priUv && !secUv) |=> !$fell(secondary_reset_n);
  endproperty
  a_mr_float: assert property (p_mr_float) else $error("open manual pin caused reset");

  property p_wd_fault;
    wdFault |=> !primary_reset_n ##1 wdCnt == CNT_ZERO;
  endproperty
  a_wd_fault: assert property (p_wd_fault) else $error("watchdog fault without reset");

  property p_wd_clear;
    (kickEdge || !chResetN[drs_pkg::CH_PRI]) |=> (wdCnt == CNT_ZERO && !wdFault);
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog counter not cleared");

  property p_wd_long;
    !primary_reset_n |=> wdMode == drs_pkg::WD_LONG;
  endproperty
  a_wd_long: assert property (p_wd_long) else $error("long timeout not restored");

  property p_wd_normal;
    (kickEdge && chResetN[drs_pkg::CH_PRI]) |=> wdMode == drs_pkg::WD_NORMAL;
  endproperty
  a_wd_normal: assert property (p_wd_normal) else $error("normal timeout not selected");

  property p_wd_off;
    wdOff |=> !wdFault && wdCnt == CNT_ZERO;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("floating watchdog still active");

  property p_aux;
    auxUv |=> (!primary_reset_n && primaryReset);
  endproperty
  a_aux: assert property (p_aux) else $error("auxiliary fault ignored");

  property p_pri_release;
    $rose(primary_reset_n) |-> quietCnt[drs_pkg::CH_PRI] == RESET_TIMEOUT_CYCLES;
  endproperty
  a_pri_release: assert property (p_pri_release) else $error("primary stretch wrong");

  property p_restart;
    (!primary_reset_n && chCause[drs_pkg::CH_PRI]) |=> chCnt[drs_pkg::CH_PRI] == CNT_ZERO;
  endproperty
  a_restart: assert property (p_restart) else $error("timer not restarted");

  property p_pfo;
    powerfail_out_n == !$past(syncIn[drs_pkg::S_PF_LOW]);
  endproperty
  a_pfo: assert property (p_pfo) else $error("power-fail output lagging");

  property p_complement;
    primaryReset == !primary_reset_n;
  endproperty
  a_complement: assert property (p_complement) else $error("reset outputs disagree");

  property p_sec_only;
    (secondary_reset_n && !chCause[drs_pkg::CH_SEC]) |=> secondary_reset_n;
  endproperty
  a_sec_only: assert property (p_sec_only) else $error("secondary reset from aux/watchdog");

  property p_sync;
    $rose(primaryUndervolt) |-> ##1 !priUv;
  endproperty
  a_sync: assert property (p_sync) else $error("flag used before synchronising");

endmodule
`default_nettype wire

// *** core/drs_pkg.sv ***
package drs_pkg;
  // clock and time base
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint NS_PER_MS = 1000000;
  // reset stretch after the last cause clears, in milliseconds
  localparam longint RESET_TIMEOUT_MS = 200;
  // watchdog timeouts, least times, in milliseconds
  localparam longint WD_LONG_MS = 35000;
  localparam longint WD_NORMAL_MS = 1120;
  // cycle counts derived from the times above; least times round up
  localparam longint RESET_TIMEOUT_CYC = (RESET_TIMEOUT_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam longint WD_LONG_CYC = (WD_LONG_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint WD_NORMAL_CYC = (WD_NORMAL_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  // counter width for every timer
  localparam int CNT_W = 32;
  // reset channels
  localparam int CH_PRI = 0;
  localparam int CH_SEC = 1;
  localparam int NUM_CH = 2;
  // synchroniser bit positions
  localparam int S_PRI_UV = 0;
  localparam int S_SEC_UV = 1;
  localparam int S_AUX_UV = 2;
  localparam int S_MR_N = 3;
  localparam int S_KICK = 4;
  localparam int S_WD_FLOAT = 5;
  localparam int S_PF_LOW = 6;
  localparam int NUM_SYNC = 7;
  // watchdog mode
  typedef enum logic [1:0] {
    WD_LONG = 2'b01,
    WD_NORMAL = 2'b10
  } drs_wd_mode_e;
endpackage

// *** testbench/drs_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module drs_cpu_model (
  input wire logic clk, // shared time base
  input wire logic kickOn, // firmware alive and servicing the watchdog
  input wire logic [7:0] halfPeriod, // cycles between toggles
  output logic watchdog_kick // gpio line toggled by firmware
);
  logic [7:0] gap = 8'h00;
  // a hung processor simply holds its last level, which is what the supervisor must catch
  initial watchdog_kick = 1'b0;
  always @(posedge clk) begin
    if (kickOn && gap >= halfPeriod) begin
      watchdog_kick <= ~watchdog_kick;
      gap <= 8'h01;
    end else begin
      gap <= gap + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  // short counts keep the run brief; expectations derive from these
  localparam int T = 8;
  localparam int LONG = 40;
  localparam int NORM = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic primaryUndervolt = 1'b0;
  logic secondaryUndervolt = 1'b0;
  logic aux_undervoltage_in = 1'b0;
  logic manual_reset_n = 1'b1;
  logic manualResetFloat = 1'b0;
  logic watchdogFloat = 1'b1;
  logic powerfail_sense_in = 1'b0;
  logic kickOn = 1'b0;
  logic [7:0] halfPeriod = 8'h04;
  logic watchdog_kick, primary_reset_n, secondary_reset_n, primaryReset, powerfail_out_n;
  int badCount = 0;
  int testsRun = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  drs_supervisor #(.RESET_TIMEOUT_CYCLES(T), .WD_LONG_CYCLES(LONG), .WD_NORMAL_CYCLES(NORM))
    dut (.clk, .rst, .primaryUndervolt, .secondaryUndervolt, .aux_undervoltage_in,
    .manual_reset_n, .manualResetFloat, .watchdog_kick, .watchdogFloat, .powerfail_sense_in,
    .primary_reset_n, .secondary_reset_n, .primaryReset, .powerfail_out_n);
  drs_cpu_model cpu (.clk, .kickOn, .halfPeriod, .watchdog_kick);
  task automatic chk(input string what, input logic exp, input logic seen);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      completeRun();
    end
  end
  task automatic at(input int n);
    repeat (n) @(posedge clk);
  endtask
  // sample between edges so registered outputs have settled
  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // aux input and watchdog never reach the secondary output
  function automatic logic secHit(input int c);
    return c != 2;
  endfunction
  task automatic setCause(input int c, input logic on);
    case (c)
      0: primaryUndervolt <= on;
      1: secondaryUndervolt <= on;
      2: aux_undervoltage_in <= on;
      default: manual_reset_n <= ~on;
    endcase
  endtask
  // called at the edge where the last cause drops
  task automatic stretchCheck(input logic secToo);
    look(T);
    chk("primary_reset_n stretch", 1'b0, primary_reset_n);
    chk("secondary_reset_n stretch", ~secToo, secondary_reset_n);
    look(8);
    chk("primary_reset_n release", 1'b1, primary_reset_n);
    chk("primaryReset release", 1'b0, primaryReset);
    chk("secondary_reset_n release", 1'b1, secondary_reset_n);
  endtask
  initial begin
    int c;
    int hold;
    void'($urandom(32'hee3e));
    at(10);
    rst <= 1'b0;
    look(2);
    chk("primary_reset_n after rst", 1'b0, primary_reset_n);
    chk("powerfail_out_n after rst", 1'b1, powerfail_out_n);
    look(T + 8);
    chk("primary_reset_n up", 1'b1, primary_reset_n);
    look(LONG + 20);
    chk("primary_reset_n wd float", 1'b1, primary_reset_n);
    $display("test reset and float done");
    for (int r = 0; r < 8; r++) begin
      c = r % 4;
      hold = 2 + ($urandom % 20);
      at(1);
      setCause(c, 1'b1);
      look(4);
      chk("primary_reset_n cause", 1'b0, primary_reset_n);
      chk("primaryReset cause", 1'b1, primaryReset);
      chk("secondary_reset_n cause", ~secHit(c), secondary_reset_n);
      look(hold);
      chk("primary_reset_n held", 1'b0, primary_reset_n);
      at(1);
      setCause(c, 1'b0);
      stretchCheck(secHit(c));
    end
    $display("test causes done");
    // a dip late in the stretch must restart the count
    at(1);
    aux_undervoltage_in <= 1'b1;
    at(3);
    aux_undervoltage_in <= 1'b0;
    at(T - 3);
    aux_undervoltage_in <= 1'b1;
    at(2);
    aux_undervoltage_in <= 1'b0;
    stretchCheck(1'b0);
    at(1);
    manualResetFloat <= 1'b1;
    manual_reset_n <= 1'b0;
    look(10);
    chk("primary_reset_n mr open", 1'b1, primary_reset_n);
    chk("secondary_reset_n mr open", 1'b1, secondary_reset_n);
    at(1);
    manual_reset_n <= 1'b1;
    manualResetFloat <= 1'b0;
    powerfail_sense_in <= 1'b1;
    look(4);
    chk("powerfail_out_n low", 1'b0, powerfail_out_n);
    chk("primary_reset_n pf", 1'b1, primary_reset_n);
    at(1);
    powerfail_sense_in <= 1'b0;
    look(4);
    chk("powerfail_out_n high", 1'b1, powerfail_out_n);
    $display("test restart, open input, power-fail done");
    at(1);
    watchdogFloat <= 1'b0;
    look(20);
    chk("primary_reset_n long wait", 1'b1, primary_reset_n);
    at(1);
    halfPeriod <= 8'(2 + $urandom % 9);
    kickOn <= 1'b1;
    look(150);
    chk("primary_reset_n kicked", 1'b1, primary_reset_n);
    @(watchdog_kick);
    kickOn <= 1'b0;
    look(NORM - 2);
    chk("primary_reset_n before fault", 1'b1, primary_reset_n);
    look(10);
    chk("primary_reset_n wd fault", 1'b0, primary_reset_n);
    chk("secondary_reset_n wd fault", 1'b1, secondary_reset_n);
    hold = 0;
    while (hold < 40 && primary_reset_n !== 1'b1) begin
      look(1);
      hold++;
    end
    look(LONG - 6);
    chk("primary_reset_n long again", 1'b1, primary_reset_n);
    look(14);
    chk("primary_reset_n long fault", 1'b0, primary_reset_n);
    $display("test watchdog done");
    completeRun();
  end
endmodule
`default_nettype wire
